// file: inc/synth_pkg.sv
// shared constants and types of the synthesizer serial load port
// assumes: one system clock domain plus the host's serial shift clock
package synth_pkg;

  // ----------------------------------------
  // word layout
  // ----------------------------------------
  localparam int WORD_W   = 24;           // bits per serial word
  localparam int SEL_W    = 2;            // latch select width, lowest bits of word
  localparam int MON_LSB  = 4;            // monitor select field position in function latch
  localparam int MON_W    = 3;            // monitor select field width

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [WORD_W-1:0] LATCH_RESET = 24'h000000;

  // ----------------------------------------
  // host timing limit, kept for reference; neither the logic nor the bench reads it
  // ----------------------------------------
  localparam int SHIFT_CLK_MAX_MHZ = 20;  // fastest serial shift clock the host may use

  // ----------------------------------------
  // latch select codes
  // ----------------------------------------
  typedef enum logic [SEL_W-1:0] {
    SEL_REF  = 2'h0,
    SEL_MAIN = 2'h1,
    SEL_FUNC = 2'h2,
    SEL_INIT = 2'h3
  } latch_sel_t;

  // ----------------------------------------
  // monitor output choices
  // ----------------------------------------
  localparam logic [MON_W-1:0] MON_LOW    = 3'h0;
  localparam logic [MON_W-1:0] MON_LOCK   = 3'h1;
  localparam logic [MON_W-1:0] MON_ACTIVE = 3'h2;
  localparam logic [MON_W-1:0] MON_PDOWN  = 3'h3;
  localparam logic [MON_W-1:0] MON_HIGH   = 3'h4;

  // one loaded serial word: payload above, latch select in the two lowest bits
  typedef struct packed {
    logic [WORD_W-SEL_W-1:0] payload;
    latch_sel_t              sel;
  } serial_word_t;

endpackage : synth_pkg

// file: hdl/synth_serial_load_port.sv
// serial load port of a pll synthesizer: shift register, latch decode, power-down and monitor mux
// assumes: host shifts msb first on rising shift clock, holds load strobe low while shifting,
// and stops the shift clock before raising the strobe
//
// What this block and its host do
// R1 - each rising shift clock edge moves the serial data bit into the 24-bit register
// R2 - a rising load strobe copies the 24 shifted bits into the addressed latch
// R3 - host keeps the shift clock at or below 20 MHz
// R4 - host holds load strobe low before and while shifting a word
// R5 - host sends one 24-bit word per latch write, possibly as three bytes
// R6 - host raises load strobe after the last bit of the third byte
// R7 - host uses clock phase zero, data set up before each rising edge
// R8 - output becomes active only after reference, main and initialization latch writes
// R9 - monitor pin shows a programmable internal signal, including the lock indicator
// R10 - host may drive power enable and poll the monitor pin for lock
// R11 - two lowest word bits pick latch: 00 ref, 01 main, 10 function, 11 init
// R12 - power enable low forces power-down at once, without any clock
// R13 - shift register and latching keep working while powered down
// R14 - words go msb first, so the latch select bits arrive last
module synth_serial_load_port
  import synth_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              shift_clk_in,
  input  wire logic              serial_data_in,
  input  wire logic              load_strobe_in,
  input  wire logic              power_enable_in,
  input  wire logic              lock_indicator_in,
  output logic [WORD_W-1:0]      ref_latch_out,
  output logic [WORD_W-1:0]      main_latch_out,
  output logic [WORD_W-1:0]      function_latch_out,
  output logic                   load_pulse_out,
  output logic                   counter_reset_pulse_out,
  output logic                   output_active_out,
  output logic                   powered_down_out,
  output logic                   monitor_output_pin_out
);

  // ----------------------------------------
  // shift clock domain
  // ----------------------------------------
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] next_shift_reg;

  // msb first, so the select bits end up in the lowest positions
  always_comb begin
    next_shift_reg = {shift_reg[WORD_W-2:0], serial_data_in}; // see R1 see R14
  end

  // no reset here: the shift clock only runs inside frames, and the word is
  // qualified by the strobe anyway; power-down never touches it
  always_ff @(posedge shift_clk_in) begin
    shift_reg <= next_shift_reg; // see R13
  end

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [1:0] strobe_sync;
  logic [1:0] next_strobe_sync;
  logic       strobe_seen;
  logic       next_strobe_seen;
  logic [1:0] enable_sync;
  logic [1:0] next_enable_sync;

  always_comb begin
    next_strobe_sync = {strobe_sync[0], load_strobe_in};
    next_strobe_seen = strobe_sync[1];
    next_enable_sync = {enable_sync[0], power_enable_in};
  end

  // two flops per pin; edge detect reads the second stage and its delayed copy strobe_seen
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      strobe_sync <= 2'h3; // idle strobe level is high, so no false rise follows reset
      strobe_seen <= 1'b1; // a strobe held low through reset only gives a fall
      enable_sync <= 2'h0;
    end else begin
      strobe_sync <= next_strobe_sync;
      strobe_seen <= next_strobe_seen;
      enable_sync <= next_enable_sync;
    end
  end

  // ----------------------------------------
  // latch decode
  // ----------------------------------------
  logic                strobe_rise;
  serial_word_t        word;
  logic [WORD_W-1:0]   ref_latch;
  logic [WORD_W-1:0]   main_latch;
  logic [WORD_W-1:0]   function_latch;
  logic [WORD_W-1:0]   next_ref_latch;
  logic [WORD_W-1:0]   next_main_latch;
  logic [WORD_W-1:0]   next_function_latch;
  logic                load_pulse;
  logic                next_load_pulse;
  logic                counter_reset_pulse;
  logic                next_counter_reset_pulse;
  logic                ref_written;
  logic                main_written;
  logic                init_written;
  logic                next_ref_written;
  logic                next_main_written;
  logic                next_init_written;
  logic                main_after_init;
  logic                next_main_after_init;

  // the shift register is read only after the strobe rise has crossed, by which
  // time the host has stopped the shift clock, so the word is quiet
  assign strobe_rise = strobe_sync[1] & ~strobe_seen; // see R2
  assign word        = serial_word_t'(shift_reg);

  always_comb begin
    next_ref_latch           = ref_latch;
    next_main_latch          = main_latch;
    next_function_latch      = function_latch;
    next_load_pulse          = 1'b0;
    next_counter_reset_pulse = 1'b0;
    next_ref_written         = ref_written;
    next_main_written        = main_written;
    next_init_written        = init_written;
    next_main_after_init     = main_after_init;
    if (strobe_rise) begin
      next_load_pulse = 1'b1; // see R2
      unique case (word.sel) // see R11
        SEL_REF: begin
          next_ref_latch   = shift_reg;
          next_ref_written = 1'b1;
        end
        SEL_MAIN: begin
          next_main_latch   = shift_reg;
          next_main_written = 1'b1;
          // the first main load after an initialization re-aligns the counters
          if (main_after_init) begin
            next_counter_reset_pulse = 1'b1;
            next_main_after_init     = 1'b0;
          end
        end
        SEL_FUNC: begin
          next_function_latch = shift_reg;
        end
        SEL_INIT: begin
          // initialization also loads the function latch and resets the counters
          next_function_latch      = shift_reg;
          next_init_written        = 1'b1; // see R8
          next_counter_reset_pulse = 1'b1;
          next_main_after_init     = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ref_latch           <= LATCH_RESET;
      main_latch          <= LATCH_RESET;
      function_latch      <= LATCH_RESET;
      load_pulse          <= 1'b0;
      counter_reset_pulse <= 1'b0;
      ref_written         <= 1'b0;
      main_written        <= 1'b0;
      init_written        <= 1'b0;
      main_after_init     <= 1'b0;
    end else begin
      ref_latch           <= next_ref_latch;
      main_latch          <= next_main_latch;
      function_latch      <= next_function_latch;
      load_pulse          <= next_load_pulse;
      counter_reset_pulse <= next_counter_reset_pulse;
      ref_written         <= next_ref_written;
      main_written        <= next_main_written;
      init_written        <= next_init_written;
      main_after_init     <= next_main_after_init;
    end
  end

  // ----------------------------------------
  // power-down
  // ----------------------------------------
  logic powered_down;
  logic next_powered_down;

  always_comb begin
    next_powered_down = ~enable_sync[1];
  end

  // entry is asynchronous to the pin; leaving waits for the synchronised high level
  // so a glitch-free release is seen by every consumer on the same edge
  always_ff @(posedge clk_in or negedge power_enable_in) begin
    if (!power_enable_in) begin
      powered_down <= 1'b1; // see R12
    end else if (reset_in) begin
      powered_down <= 1'b1;
    end else begin
      powered_down <= next_powered_down;
    end
  end

  // ----------------------------------------
  // output activity and monitor mux
  // ----------------------------------------
  logic             output_active;
  logic             next_output_active;
  logic             monitor;
  logic             next_monitor;
  logic [MON_W-1:0] mon_sel;

  assign mon_sel = function_latch[MON_LSB +: MON_W];

  always_comb begin
    next_output_active = ref_written & main_written & init_written & ~powered_down; // see R8
    unique case (mon_sel) // see R9
      MON_LOW:    next_monitor = 1'b0;
      MON_LOCK:   next_monitor = lock_indicator_in;
      MON_ACTIVE: next_monitor = output_active;
      MON_PDOWN:  next_monitor = powered_down;
      MON_HIGH:   next_monitor = 1'b1;
      default:    next_monitor = 1'b0; // unused codes read low
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      output_active <= 1'b0;
      monitor       <= 1'b0;
    end else begin
      output_active <= next_output_active;
      monitor       <= next_monitor;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------
  assign ref_latch_out           = ref_latch;
  assign main_latch_out          = main_latch;
  assign function_latch_out      = function_latch;
  assign load_pulse_out          = load_pulse;
  assign counter_reset_pulse_out = counter_reset_pulse;
  assign output_active_out       = output_active;
  assign powered_down_out        = powered_down;
  assign monitor_output_pin_out  = monitor;

endmodule : synth_serial_load_port

// file: verification/serial_host_model.sv
// host side of the serial load link: drives shift clock, data and load strobe
// assumes: caller picks the half period; shift clock stays low outside frames
module serial_host_model (
  output logic shift_clk_out,
  output logic serial_data_out,
  output logic load_strobe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    shift_clk_out   = 1'b0;
    serial_data_out = 1'b0;
    load_strobe_out = 1'b1;
  end
  // -----------------------------
  // one word: strobe low, 24 bits msb first, strobe high
  // -----------------------------
  // hp of 25 ns or more keeps the shift clock at or under 20 mhz
  task automatic send(input logic [23:0] w, input int hp);
    load_strobe_out = 1'b0;
    #(3 * hp);
    for (int i = 23; i >= 0; i--) begin
      serial_data_out = w[i];
      #hp shift_clk_out = 1'b1;
      #hp shift_clk_out = 1'b0;
    end
    // data line released: show the inverse so stale bits cannot pass
    serial_data_out = ~w[0];
    #hp load_strobe_out = 1'b1;
  endtask : send
endmodule : serial_host_model

// file: verification/synth_serial_load_port_sva.sv
// port checker for the serial load port
// assumes: bound to the design top, all checks in the clk_in domain
module synth_serial_load_port_sva
  import synth_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              reset_in,
  input wire logic              load_strobe_in,
  input wire logic              power_enable_in,
  input wire logic              lock_indicator_in,
  input wire logic [WORD_W-1:0] ref_latch_out,
  input wire logic [WORD_W-1:0] main_latch_out,
  input wire logic [WORD_W-1:0] function_latch_out,
  input wire logic              load_pulse_out,
  input wire logic              counter_reset_pulse_out,
  input wire logic              output_active_out,
  input wire logic              powered_down_out,
  input wire logic              monitor_output_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // -----------------------------
  // loading and latches
  // -----------------------------
  a_load_after_strobe: assert property ($rose(load_strobe_in) |-> ##[2:5] load_pulse_out)
    else $error("no load pulse after strobe rise");
  a_pulse_needs_strobe: assert property (load_pulse_out |-> $past(load_strobe_in, 2))
    else $error("load pulse without strobe");
  a_pulse_one_cycle: assert property (load_pulse_out |=> !load_pulse_out)
    else $error("load pulse longer than one cycle");
  a_latch_only_load: assert property (($changed(ref_latch_out) || $changed(main_latch_out)
    || $changed(function_latch_out)) |-> load_pulse_out) else $error("latch changed without load");
  a_reset_pulse_load: assert property (counter_reset_pulse_out |-> load_pulse_out)
    else $error("counter reset pulse without load");
  // -----------------------------
  // power-down and monitor pin
  // -----------------------------
  a_pdown_at_once: assert property (!power_enable_in |-> powered_down_out)
    else $error("power-down not immediate");
  a_pdown_release: assert property (power_enable_in [*5] |-> !powered_down_out)
    else $error("power-down not released");
  a_idle_when_down: assert property (powered_down_out && $past(powered_down_out) |-> !output_active_out)
    else $error("output active while powered down");
  a_monitor_lock: assert property (function_latch_out[6:4] == MON_LOCK |=>
    monitor_output_pin_out == $past(lock_indicator_in)) else $error("monitor not showing lock");
  a_monitor_pdown: assert property (function_latch_out[6:4] == MON_PDOWN |=>
    monitor_output_pin_out == $past(powered_down_out)) else $error("monitor not showing power-down");
  a_monitor_high: assert property (function_latch_out[6:4] == MON_HIGH |=> monitor_output_pin_out)
    else $error("monitor not high");
  c_init_pulse: cover property (counter_reset_pulse_out);
  c_active: cover property ($rose(output_active_out));
  c_pdown_load: cover property (powered_down_out && load_pulse_out);
endmodule : synth_serial_load_port_sva

bind synth_serial_load_port synth_serial_load_port_sva chk (.*);

// file: verification/synth_serial_load_port_tb.sv
// self-checking bench of the serial load port
// assumes: host model drives the link, bench drives the rest on clk_in
module synth_serial_load_port_tb;
  import synth_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, reset_in = 1'b1, power_enable_in = 1'b1, lock_indicator_in = 1'b0;
  logic shift_clk_in, serial_data_in, load_strobe_in;
  logic [WORD_W-1:0] ref_latch_out, main_latch_out, function_latch_out;
  logic load_pulse_out, counter_reset_pulse_out, output_active_out, powered_down_out, monitor_output_pin_out;
  int error_cnt = 0, checks = 0;
  logic crp;
  initial forever #10 clk_in = ~clk_in;
  serial_host_model host (.shift_clk_out(shift_clk_in), .serial_data_out(serial_data_in),
    .load_strobe_out(load_strobe_in));
  synth_serial_load_port DUT (.*);
  // -----------------------------
  // shared tasks
  // -----------------------------
  task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up();
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // send a word and wait, bounded, for the load pulse; notes any counter reset pulse
  task automatic load(input logic [WORD_W-1:0] w, input int hp);
    int n;
    crp = 1'b0;
    host.send(w, hp);
    for (n = 0; n < 10; n++) begin
      @(posedge clk_in);
      #1;
      if (counter_reset_pulse_out === 1'b1) crp = 1'b1;
      if (load_pulse_out === 1'b1) break;
    end
    if (n == 10) begin
      error_cnt++;
      wrap_up();
    end
  endtask : load
  // -----------------------------
  // scenarios
  // -----------------------------
  task automatic t_startup();
    load(24'hc5a343, 25);
    check("init to function", function_latch_out, 24'hc5a343);
    check("init pulse", crp, 1'b1);
    load(24'h5a5a5c, 60);
    check("ref latch", ref_latch_out, 24'h5a5a5c);
    check("not yet active", output_active_out, 1'b0);
    load(24'h3c3c3d, 25);
    check("main latch", main_latch_out, 24'h3c3c3d);
    check("first main pulse", crp, 1'b1);
    repeat (2) @(posedge clk_in);
    #1 check("active", output_active_out, 1'b1);
    load(24'h81818d, 25);
    check("later main pulse", crp, 1'b0);
    check("second main", main_latch_out, 24'h81818d);
    check("monitor high", monitor_output_pin_out, 1'b1);
  endtask : t_startup
  task automatic t_monitor();
    load(24'h000016, 25);
    check("function latch", function_latch_out, 24'h000016);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk_in) lock_indicator_in <= v[0];
      repeat (3) @(posedge clk_in);
      #1 check("monitor lock", monitor_output_pin_out, v[0]);
    end
  endtask : t_monitor
  task automatic t_pdown();
    @(posedge clk_in) power_enable_in <= 1'b0;
    #1 check("power-down", powered_down_out, 1'b1);
    load(24'h123454, 60);
    check("ref while down", ref_latch_out, 24'h123454);
    check("inactive down", output_active_out, 1'b0);
    // monitor on power-down state, then on output activity, then tied low
    load(24'h000032, 25);
    @(posedge clk_in);
    #1 check("monitor pdown", monitor_output_pin_out, 1'b1);
    @(posedge clk_in) power_enable_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    #1 check("power up", powered_down_out, 1'b0);
    check("monitor up", monitor_output_pin_out, 1'b0);
    load(24'h000022, 25);
    @(posedge clk_in);
    #1 check("monitor active", monitor_output_pin_out, 1'b1);
    load(24'h000002, 25);
    @(posedge clk_in);
    #1 check("monitor low", monitor_output_pin_out, 1'b0);
  endtask : t_pdown
  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    t_startup();
    t_monitor();
    t_pdown();
    wrap_up();
  end
endmodule : synth_serial_load_port_tb
